// *** ccrs_board_model.sv ***
// Board model: PLL lock source and test reset follower for the ratio select block
`timescale 1ns/1ps

module ccrs_board_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // PLL control from the device and lock delay set by the bench
  input wire logic pllEnable,
  input wire logic [7:0] lockDelay,
  // Lock status and test reset
  output logic pllLock,
  output logic trstN
);
  logic [7:0] waitCnt_reg;

  assign trstN = arst_n;

  // Lock comes a set delay after enable and drops when the PLL is stopped
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      waitCnt_reg <= 8'h00;
      pllLock <= 1'h0;
    end else if (!pllEnable) begin
      waitCnt_reg <= 8'h00;
      pllLock <= 1'h0;
    end else if (waitCnt_reg >= lockDelay) begin
      pllLock <= 1'h1;
    end else begin
      waitCnt_reg <= waitCnt_reg + 8'h01;
    end
  end
endmodule : ccrs_board_model

// *** ccrs_core_clock_ratio_select.sv ***
// Core clock ratio select: strap capture, ratio decode and lock-gated clock enable
// Function
// - Core clock is derived from PCI reference clock using the four-bit select code.
// - With VCO times 4, code 0001 gives ratio 1, code 0010 ratio 2.
// - With VCO times 2, codes 0101, 1000, 1010 give ratios 2, 3, 4.
// - With VCO times 2, codes 1001, 1100, 1101 give ratios 1.5, 2.5, 1.
// - Code 0011 bypasses the PLL, core runs directly at 1:1.
// - Code 1111 stops all internal clocking.
// - Select inputs are sampled while in reset and configure the device.
`timescale 1ns/1ps

module ccrs_core_clock_ratio_select #(
  parameter int LOCK_CYCLES = ccrs_pkg::LOCK_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Strap pins and PLL status
  input wire logic [3:0] ratioSel,
  input wire logic pllLock,
  // Clock generator control
  output ccrs_pkg::ccrs_cfg_t cfgOut,
  output logic pllEnable,
  output logic bypassSel,
  output logic coreClkEn,
  output logic cfgReserved
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta_reg;
  logic rstSync_reg;

  // Two flops release the asynchronous reset on the clock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Strap sampling
  // ----------------------------------------------------------------
  logic [3:0] selS1_reg;
  logic [3:0] selS2_reg;
  logic [3:0] selS3_reg;
  logic [3:0] code_reg;
  logic [3:0] code_next;

  // Three-flop input stage, free running so the straps are seen during reset
  always_ff @(posedge ref_clk) begin
    selS1_reg <= ratioSel;
    selS2_reg <= selS1_reg;
    selS3_reg <= selS2_reg;
  end

  // Follow agreed value while in reset, freeze after release
  always_comb begin
    code_next = code_reg;
    if (!rstSync_reg && (selS2_reg == selS3_reg)) begin
      code_next = selS3_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    code_reg <= code_next;
  end

  // ----------------------------------------------------------------
  // Ratio decode
  // ----------------------------------------------------------------
  ccrs_pkg::ccrs_cfg_t cfg_next;

  always_comb begin
    cfg_next.mode = ccrs_pkg::MODE_PLL;
    cfg_next.halfRatio = '0;
    cfg_next.vcoMult = ccrs_pkg::VCO_NONE;
    case (code_reg)
      ccrs_pkg::CODE_X1_V4: begin
        cfg_next.halfRatio = ccrs_pkg::HALF_1;
        cfg_next.vcoMult = ccrs_pkg::VCO_4;
      end
      ccrs_pkg::CODE_X2_V4: begin
        cfg_next.halfRatio = ccrs_pkg::HALF_2;
        cfg_next.vcoMult = ccrs_pkg::VCO_4;
      end
      // integer ratios on VCO times 2
      ccrs_pkg::CODE_X2_V2: begin
        cfg_next.halfRatio = ccrs_pkg::HALF_2;
        cfg_next.vcoMult = ccrs_pkg::VCO_2;
      end
      ccrs_pkg::CODE_X3_V2: begin
        cfg_next.halfRatio = ccrs_pkg::HALF_3;
        cfg_next.vcoMult = ccrs_pkg::VCO_2;
      end
      ccrs_pkg::CODE_X4_V2: begin
        cfg_next.halfRatio = ccrs_pkg::HALF_4;
        cfg_next.vcoMult = ccrs_pkg::VCO_2;
      end
      // half and unit ratios on VCO times 2
      ccrs_pkg::CODE_X15_V2: begin
        cfg_next.halfRatio = ccrs_pkg::HALF_15;
        cfg_next.vcoMult = ccrs_pkg::VCO_2;
      end
      ccrs_pkg::CODE_X25_V2: begin
        cfg_next.halfRatio = ccrs_pkg::HALF_25;
        cfg_next.vcoMult = ccrs_pkg::VCO_2;
      end
      ccrs_pkg::CODE_X1_V2: begin
        cfg_next.halfRatio = ccrs_pkg::HALF_1;
        cfg_next.vcoMult = ccrs_pkg::VCO_2;
      end
      ccrs_pkg::CODE_BYPASS: begin
        cfg_next.mode = ccrs_pkg::MODE_BYPASS;
        cfg_next.halfRatio = ccrs_pkg::HALF_1;
      end
      ccrs_pkg::CODE_OFF: begin
        cfg_next.mode = ccrs_pkg::MODE_OFF;
      end
      // reserved codes flagged, clocks kept off
      default: begin
        cfg_next.mode = ccrs_pkg::MODE_BAD;
      end
    endcase
  end

  // Registered configuration outputs, held off until the released reset copy
  always_ff @(posedge ref_clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      cfgOut <= '{mode: ccrs_pkg::MODE_OFF, halfRatio: '0, vcoMult: ccrs_pkg::VCO_NONE};
      pllEnable <= 1'b0;
      bypassSel <= 1'b0;
      cfgReserved <= 1'b0;
    end else begin
      cfgOut <= cfg_next;
      pllEnable <= cfg_next.mode == ccrs_pkg::MODE_PLL;
      bypassSel <= cfg_next.mode == ccrs_pkg::MODE_BYPASS;
      cfgReserved <= cfg_next.mode == ccrs_pkg::MODE_BAD;
    end
  end

  // ----------------------------------------------------------------
  // Lock wait and core clock gate
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RESET,
    ST_WAIT,
    ST_RUN,
    ST_HALT
  } ccrs_state_t;

  ccrs_state_t state_reg;
  logic [31:0] lockCnt_reg;
  logic lockS1_reg;
  logic lockS2_reg;
  logic lockS3_reg;
  logic lockOk_reg;

  // Lock input from the analog PLL passes three flops
  always_ff @(posedge ref_clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      lockS1_reg <= 1'b0;
      lockS2_reg <= 1'b0;
      lockS3_reg <= 1'b0;
      lockOk_reg <= 1'b0;
    end else begin
      lockS1_reg <= pllLock;
      lockS2_reg <= lockS1_reg;
      lockS3_reg <= lockS2_reg;
      if (lockS2_reg == lockS3_reg) begin
        lockOk_reg <= lockS3_reg;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      state_reg <= ST_RESET;
      lockCnt_reg <= '0;
      coreClkEn <= 1'b0;
    end else begin
      case (state_reg)
        ST_RESET: begin
          coreClkEn <= 1'b0;
          lockCnt_reg <= '0;
          // Decode, not cfgOut, which is loaded on this same edge
          case (cfg_next.mode)
            ccrs_pkg::MODE_PLL: state_reg <= ST_WAIT;
            ccrs_pkg::MODE_BYPASS: state_reg <= ST_RUN;
            default: state_reg <= ST_HALT;
          endcase
        end
        ST_WAIT: begin
          if (lockOk_reg && lockCnt_reg >= 32'(LOCK_CYCLES - 1)) begin
            state_reg <= ST_RUN;
          end else begin
            lockCnt_reg <= lockCnt_reg + 32'h0000_0001;
          end
        end
        ST_RUN: begin
          coreClkEn <= 1'b1;
        end
        ST_HALT: begin
          coreClkEn <= 1'b0;
        end
        default: state_reg <= ST_HALT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_off_no_clock;
    @(posedge ref_clk) disable iff (!rstSync_reg)
    (cfgOut.mode == ccrs_pkg::MODE_OFF) |-> !coreClkEn && !pllEnable;
  endproperty
  a_off_no_clock: assert property (p_off_no_clock) else $error("clock on in off mode");

  property p_bypass_ratio;
    @(posedge ref_clk) disable iff (!rstSync_reg)
    bypassSel |-> !pllEnable && cfgOut.halfRatio == ccrs_pkg::HALF_1;
  endproperty
  a_bypass_ratio: assert property (p_bypass_ratio) else $error("bypass not 1:1");

  property p_code_frozen;
    @(posedge ref_clk) disable iff (!rstSync_reg)
    rstSync_reg && $past(rstSync_reg) |-> $stable(code_reg);
  endproperty
  a_code_frozen: assert property (p_code_frozen) else $error("code changed after reset");

  property p_clk_needs_lock;
    @(posedge ref_clk) disable iff (!rstSync_reg)
    $rose(coreClkEn) && pllEnable |-> lockOk_reg;
  endproperty
  a_clk_needs_lock: assert property (p_clk_needs_lock) else $error("core clock before lock");

  property p_vco4;
    @(posedge ref_clk) disable iff (!rstSync_reg)
    (code_reg == ccrs_pkg::CODE_X2_V4) |=> cfgOut.vcoMult == ccrs_pkg::VCO_4
      && cfgOut.halfRatio == ccrs_pkg::HALF_2;
  endproperty
  a_vco4: assert property (p_vco4) else $error("code 0010 decode wrong");

  property p_reserved;
    @(posedge ref_clk) disable iff (!rstSync_reg)
    cfgReserved |-> !coreClkEn;
  endproperty
  a_reserved: assert property (p_reserved) else $error("clock on with reserved code");

endmodule : ccrs_core_clock_ratio_select

// *** ccrs_pkg.sv ***
// Package for the core clock ratio select block: codes, ratios and timing
package ccrs_pkg;

  // Ratio select code width
  localparam int CODE_W = 4;

  // Ratio select codes
  localparam logic [3:0] CODE_X1_V4 = 4'h1;
  localparam logic [3:0] CODE_X2_V4 = 4'h2;
  localparam logic [3:0] CODE_BYPASS = 4'h3;
  localparam logic [3:0] CODE_X2_V2 = 4'h5;
  localparam logic [3:0] CODE_X3_V2 = 4'h8;
  localparam logic [3:0] CODE_X15_V2 = 4'h9;
  localparam logic [3:0] CODE_X4_V2 = 4'hA;
  localparam logic [3:0] CODE_X25_V2 = 4'hC;
  localparam logic [3:0] CODE_X1_V2 = 4'hD;
  localparam logic [3:0] CODE_OFF = 4'hF;

  // Ratio in half steps (core = pci * half / 2), field widths
  localparam int HALF_W = 4;
  localparam logic [3:0] HALF_1 = 4'h2;
  localparam logic [3:0] HALF_15 = 4'h3;
  localparam logic [3:0] HALF_2 = 4'h4;
  localparam logic [3:0] HALF_25 = 4'h5;
  localparam logic [3:0] HALF_3 = 4'h6;
  localparam logic [3:0] HALF_4 = 4'h8;

  // VCO multipliers
  localparam logic [2:0] VCO_2 = 3'h2;
  localparam logic [2:0] VCO_4 = 3'h4;
  localparam logic [2:0] VCO_NONE = 3'h0;

  // Clock-off code value; the captured code has no reset and follows the straps
  localparam logic [3:0] CODE_RST = 4'hF;

  // Lock wait time and cycle count at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int LOCK_US = 100;
  localparam int LOCK_CYC = LOCK_US * CLK_MHZ;

  // Mode of the clock generator
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_PLL,
    MODE_BYPASS,
    MODE_BAD
  } ccrs_mode_t;

  // Decoded configuration carried as one bundle
  typedef struct packed {
    ccrs_mode_t mode;
    logic [3:0] halfRatio;
    logic [2:0] vcoMult;
  } ccrs_cfg_t;

endpackage : ccrs_pkg

// *** test_core_clock_ratio_select.sv ***
// Testbench for the core clock ratio select block
`timescale 1ns/1ps

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end

module test_core_clock_ratio_select;
  logic ref_clk = 1'h0;
  logic arst_n = 1'h0;
  logic [3:0] ratioSel = 4'hF;
  logic [7:0] lockDelay = 8'h02;
  logic pllLock;
  logic trstN;
  ccrs_pkg::ccrs_cfg_t cfgOut;
  logic pllEnable;
  logic bypassSel;
  logic coreClkEn;
  logic cfgReserved;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  // only listed straps outside the reserved scenario
  logic [3:0] pllCodes [8] = '{4'h1, 4'h2, 4'h5, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD};
  logic [3:0] halfs [8] = '{4'h2, 4'h4, 4'h4, 4'h6, 4'h3, 4'h8, 4'h5, 4'h2};
  logic [2:0] vcos [8] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2};
  logic [3:0] rsvCodes [6] = '{4'h0, 4'h4, 4'h6, 4'h7, 4'hB, 4'hE};

  ccrs_core_clock_ratio_select #(.LOCK_CYCLES(8)) uut (
    .ref_clk(ref_clk), .arst_n(arst_n), .ratioSel(ratioSel), .pllLock(pllLock),
    .cfgOut(cfgOut), .pllEnable(pllEnable), .bypassSel(bypassSel),
    .coreClkEn(coreClkEn), .cfgReserved(cfgReserved));

  ccrs_board_model board (
    .ref_clk(ref_clk), .arst_n(arst_n), .pllEnable(pllEnable),
    .lockDelay(lockDelay), .pllLock(pllLock), .trstN(trstN));

  // Clock at 100 MHz
  // reference clock source
  always #5 ref_clk = ~ref_clk;

  // Reset with a strap code, then release
  task automatic apply_reset(input logic [3:0] code);
    @(posedge ref_clk);
    arst_n <= 1'h0;
    ratioSel <= code;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'h1;
  endtask : apply_reset

  // Wait a bounded time for the core clock gate
  task automatic wait_core(input int limit);
    int n;
    n = 0;
    while (coreClkEn !== 1'h1 && n < limit) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_core

  // Every PLL code: decode, enable, gate held until count and lock
  task automatic test_pll_codes();
    lockDelay <= 8'h02;
    for (int i = 0; i < 8; i++) begin
      apply_reset(pllCodes[i]);
      repeat (6) @(negedge ref_clk);
      `CHK("coreClkEn early", 1'h0, coreClkEn)
      `CHK("cfgOut", {ccrs_pkg::MODE_PLL, halfs[i], vcos[i]}, cfgOut)
      `CHK("pllEnable", 1'h1, pllEnable)
      `CHK("bypassSel", 1'h0, bypassSel)
      `CHK("cfgReserved", 1'h0, cfgReserved)
      wait_core(40);
      `CHK("coreClkEn", 1'h1, coreClkEn)
    end
  endtask : test_pll_codes

  // Slow lock holds the gate; strap change after release is ignored
  task automatic test_lock_gate();
    lockDelay <= 8'h3C;
    apply_reset(ccrs_pkg::CODE_X3_V2);
    @(posedge ref_clk);
    ratioSel <= ccrs_pkg::CODE_OFF;
    repeat (40) @(negedge ref_clk);
    `CHK("coreClkEn no lock", 1'h0, coreClkEn)
    wait_core(60);
    `CHK("coreClkEn locked", 1'h1, coreClkEn)
    `CHK("cfgOut kept", {ccrs_pkg::MODE_PLL, ccrs_pkg::HALF_3, ccrs_pkg::VCO_2}, cfgOut)
  endtask : test_lock_gate

  // Bypass runs without lock and keeps the PLL off
  task automatic test_bypass();
    lockDelay <= 8'hFF;
    apply_reset(ccrs_pkg::CODE_BYPASS);
    wait_core(10);
    `CHK("coreClkEn bypass", 1'h1, coreClkEn)
    `CHK("bypassSel", 1'h1, bypassSel)
    `CHK("pllEnable bypass", 1'h0, pllEnable)
    `CHK("mode bypass", ccrs_pkg::MODE_BYPASS, cfgOut.mode)
  endtask : test_bypass

  // Clock off gives no clocking at all
  task automatic test_off();
    lockDelay <= 8'h00;
    apply_reset(ccrs_pkg::CODE_OFF);
    repeat (30) @(negedge ref_clk);
    `CHK("coreClkEn off", 1'h0, coreClkEn)
    `CHK("pllEnable off", 1'h0, pllEnable)
    `CHK("bypassSel off", 1'h0, bypassSel)
    `CHK("mode off", ccrs_pkg::MODE_OFF, cfgOut.mode)
  endtask : test_off

  // Reserved straps, presented here on purpose, are flagged and give no clock
  task automatic test_reserved();
    lockDelay <= 8'h00;
    for (int i = 0; i < 6; i++) begin
      apply_reset(rsvCodes[i]);
      repeat (30) @(negedge ref_clk);
      `CHK("cfgReserved", 1'h1, cfgReserved)
      `CHK("mode bad", ccrs_pkg::MODE_BAD, cfgOut.mode)
      `CHK("coreClkEn rsv", 1'h0, coreClkEn)
      `CHK("pllEnable rsv", 1'h0, pllEnable)
    end
  endtask : test_reserved

  // Final verdict and end of run
  task automatic give_verdict();
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    test_pll_codes();
    test_lock_gate();
    test_bypass();
    test_off();
    test_reserved();
    give_verdict();
  end
endmodule : test_core_clock_ratio_select
